// ==== design/rcb_params.svh ====
`ifndef RCB_PARAMS_SVH
`define RCB_PARAMS_SVH
// ****************************************
// offsets
// ****************************************
`define RCB_OFF_A_PIN 8'h00
`define RCB_OFF_B_PIN 8'h01
`define RCB_OFF_A_MODE 8'h02
`define RCB_OFF_B_MODE 8'h03
`define RCB_OFF_A_OUT 8'h04
`define RCB_OFF_B_OUT 8'h05
`define RCB_OFF_A_DIR 8'h06
`define RCB_OFF_B_DIR 8'h07
`define RCB_OFF_A_DRV 8'h08
`define RCB_OFF_B_DRV 8'h09
`define RCB_OFF_A_IN_CELL 8'h0A
`define RCB_OFF_B_IN_CELL 8'h0B
`define RCB_OFF_A_DRV_ON 8'h0C
`define RCB_OFF_B_DRV_ON 8'h0D
`define RCB_OFF_C_PIN 8'h10
`define RCB_OFF_D_PIN 8'h11
`define RCB_OFF_C_OUT 8'h12
`define RCB_OFF_D_OUT 8'h13
`define RCB_OFF_C_DIR 8'h14
`define RCB_OFF_D_DIR 8'h15
`define RCB_OFF_C_DRV 8'h16
`define RCB_OFF_D_DRV 8'h17
`define RCB_OFF_C_IN_CELL 8'h18
`define RCB_OFF_C_DRV_ON 8'h1A
`define RCB_OFF_D_DRV_ON 8'h1B
`define RCB_OFF_CELL_FIRST 8'h20
`define RCB_OFF_CELL_SECOND 8'h21
`define RCB_OFF_MASK_FIRST 8'h22
`define RCB_OFF_MASK_SECOND 8'h23
`define RCB_OFF_PWR_FIRST 8'hB0
`define RCB_OFF_PWR_SECOND 8'hB4
`define RCB_OFF_MAIN_PROT 8'hC0
`define RCB_OFF_SEC_PROT 8'hC2
`define RCB_OFF_PWR_THIRD 8'hC7
`define RCB_OFF_PAGE 8'hE0
`define RCB_OFF_ROUTING 8'hE2
// ****************************************
// fields and reset values
// ****************************************
`define RCB_PWR3_STICKY_BIT 1
`define RCB_RT_PIO_BIT 7
`define RCB_RT_MAIN_DATA_BIT 4
`define RCB_RT_SEC_DATA_BIT 3
`define RCB_RT_MAIN_FETCH_BIT 2
`define RCB_RT_SEC_FETCH_BIT 1
`define RCB_RT_NV_MASK 8'h1E
`define RCB_RST_BYTE 8'h00
`define RCB_RST_DRIVE 8'h00
`define RCB_UNUSED_READ 8'h00
`endif

// ==== design/rcb_pkg.sv ====
`default_nettype none
package rcb_pkg;
  typedef logic [7:0] rcb_byte_t;
  // ****************************************
  // per-port pin views and controls, bus and routing
  // ****************************************
  typedef struct packed {
    rcb_byte_t pin_level;
    rcb_byte_t in_cells;
    rcb_byte_t cell_out;
  } rcb_port_in_t;
  typedef struct packed {
    rcb_byte_t level;
    rcb_byte_t dir;
    rcb_byte_t drive;
    rcb_byte_t mode;
  } rcb_port_ctl_t;
  typedef struct packed {
    logic wr;
    logic rd;
    rcb_byte_t addr;
    rcb_byte_t wdata;
  } rcb_bus_t;
  typedef struct packed {
    logic main_data;
    logic sec_data;
    logic main_fetch;
    logic sec_fetch;
    logic pio_mode;
  } rcb_route_t;
endpackage : rcb_pkg
`default_nettype wire

// ==== design/rcb_pin_sync.sv ====
`default_nettype none
module rcb_pin_sync #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // pin side
  input wire logic [WIDTH-1:0] i_pins,
  // synchronised side
  output logic [WIDTH-1:0] o_level
);
  import rcb_pkg::*;
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] lvl;
  } rcb_sync_st_t;
  rcb_sync_st_t st;
  rcb_sync_st_t next_st;
  always_comb begin
    next_st = st;
    next_st.s1 = i_pins;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    // change counts once stages two and three agree
    for (int i = 0; i < WIDTH; i++) begin
      if (st.s2[i] == st.s3[i]) begin
        next_st.lvl[i] = st.s3[i];
      end
    end
  end
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign o_level = st.lvl;
endmodule : rcb_pin_sync
`default_nettype wire

// ==== design/rcb_decode.sv ====
`default_nettype none
`include "rcb_params.svh"
module rcb_decode (
  // core data bus
  input wire logic [15:0] i_addr,
  input wire logic [15:0] i_base,
  // decoded
  output logic o_hit,
  output logic [7:0] o_offset
);
  import rcb_pkg::*;
  logic [15:0] diff;
  // relocatable window of 256 locations
  always_comb begin
    diff = i_addr - i_base;
    o_hit = (i_addr[15:8] == i_base[15:8]);
    o_offset = diff[7:0];
  end
endmodule : rcb_decode
`default_nettype wire

// ==== design/rcb_bank.sv ====
`default_nettype none
`include "rcb_params.svh"
module rcb_bank #(
  parameter logic [15:0] BASE_ADDR = 16'h0000,
  parameter logic [7:0] MAIN_PROT_NV = 8'h00,
  parameter logic [7:0] SEC_PROT_NV = 8'h00,
  parameter logic [7:0] ROUTE_NV = 8'h00
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // core data bus, byte wide
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [15:0] i_addr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  // pins and logic-cell views, ports a to d
  input wire rcb_pkg::rcb_port_in_t i_port_a,
  input wire rcb_pkg::rcb_port_in_t i_port_b,
  input wire rcb_pkg::rcb_port_in_t i_port_c,
  input wire rcb_pkg::rcb_port_in_t i_port_d,
  input wire logic [7:0] i_drv_on_a,
  input wire logic [7:0] i_drv_on_b,
  input wire logic [7:0] i_drv_on_c,
  input wire logic [7:0] i_drv_on_d,
  // output logic cells: states in, loads out
  input wire logic [7:0] i_cells_first,
  input wire logic [7:0] i_cells_second,
  input wire logic i_secure,
  output logic [7:0] o_cell_load_first,
  output logic [7:0] o_cell_load_second,
  output logic [7:0] o_cell_data,
  // port controls
  output rcb_pkg::rcb_port_ctl_t o_ctl_a,
  output rcb_pkg::rcb_port_ctl_t o_ctl_b,
  output rcb_pkg::rcb_port_ctl_t o_ctl_c,
  output rcb_pkg::rcb_port_ctl_t o_ctl_d,
  // memory control
  output logic [7:0] o_pwr_first,
  output logic [7:0] o_pwr_second,
  output logic [7:0] o_pwr_third,
  output logic [7:0] o_page,
  output rcb_pkg::rcb_route_t o_route
);
  import rcb_pkg::*;

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    rcb_byte_t a_mode;
    rcb_byte_t b_mode;
    rcb_byte_t [3:0] out_lvl;
    rcb_byte_t [3:0] dir;
    rcb_byte_t [3:0] drive;
    rcb_byte_t mask_first;
    rcb_byte_t mask_second;
    rcb_byte_t load_first;
    rcb_byte_t load_second;
    rcb_byte_t cell_data;
    rcb_byte_t pwr_first;
    rcb_byte_t pwr_second;
    rcb_byte_t pwr_third;
    rcb_byte_t page;
    rcb_byte_t route;
    logic route_loaded;
    rcb_byte_t rdata;
  } rcb_state_t;
  rcb_state_t st;
  rcb_state_t next_st;

  logic hit;
  logic [7:0] off;
  logic [31:0] pin_raw;
  logic [31:0] pin_sync;
  logic [7:0] ctl_reset_route;

  // ****************************************
  // decode and pin synchronisers
  // ****************************************
  rcb_decode u_decode (
    .i_addr(i_addr),
    .i_base(BASE_ADDR),
    .o_hit(hit),
    .o_offset(off)
  );

  // pins arrive from outside the clock domain
  assign pin_raw = {i_port_d.pin_level, i_port_c.pin_level,
                    i_port_b.pin_level, i_port_a.pin_level};
  rcb_pin_sync #(.WIDTH(32)) u_pin_sync (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_pins(pin_raw),
    .o_level(pin_sync)
  );

  // masked view of an output-cell bank: masked bits read zero
  function automatic rcb_byte_t cell_view(input rcb_byte_t cells, input rcb_byte_t mask);
    cell_view = cells & ~mask;
  endfunction

  // pure read mux, unmapped offsets read zero
  function automatic rcb_byte_t read_mux(input logic [7:0] o, input rcb_state_t s,
                                         input logic [31:0] pins);
    unique case (o)
      `RCB_OFF_A_PIN: read_mux = pins[7:0];
      `RCB_OFF_B_PIN: read_mux = pins[15:8];
      `RCB_OFF_C_PIN: read_mux = pins[23:16];
      `RCB_OFF_D_PIN: read_mux = pins[31:24];
      `RCB_OFF_A_MODE: read_mux = s.a_mode;
      `RCB_OFF_B_MODE: read_mux = s.b_mode;
      `RCB_OFF_A_OUT: read_mux = s.out_lvl[0];
      `RCB_OFF_B_OUT: read_mux = s.out_lvl[1];
      `RCB_OFF_C_OUT: read_mux = s.out_lvl[2];
      `RCB_OFF_D_OUT: read_mux = s.out_lvl[3];
      `RCB_OFF_A_DIR: read_mux = s.dir[0];
      `RCB_OFF_B_DIR: read_mux = s.dir[1];
      `RCB_OFF_C_DIR: read_mux = s.dir[2];
      `RCB_OFF_D_DIR: read_mux = s.dir[3];
      `RCB_OFF_A_DRV: read_mux = s.drive[0];
      `RCB_OFF_B_DRV: read_mux = s.drive[1];
      `RCB_OFF_C_DRV: read_mux = s.drive[2];
      `RCB_OFF_D_DRV: read_mux = s.drive[3];
      `RCB_OFF_A_IN_CELL: read_mux = i_port_a.in_cells;
      `RCB_OFF_B_IN_CELL: read_mux = i_port_b.in_cells;
      `RCB_OFF_C_IN_CELL: read_mux = i_port_c.in_cells;
      `RCB_OFF_A_DRV_ON: read_mux = i_drv_on_a;
      `RCB_OFF_B_DRV_ON: read_mux = i_drv_on_b;
      `RCB_OFF_C_DRV_ON: read_mux = i_drv_on_c;
      `RCB_OFF_D_DRV_ON: read_mux = i_drv_on_d;
      `RCB_OFF_CELL_FIRST: read_mux = cell_view(i_cells_first, s.mask_first);
      `RCB_OFF_CELL_SECOND: read_mux = cell_view(i_cells_second, s.mask_second);
      `RCB_OFF_MASK_FIRST: read_mux = s.mask_first;
      `RCB_OFF_MASK_SECOND: read_mux = s.mask_second;
      `RCB_OFF_PWR_FIRST: read_mux = s.pwr_first;
      `RCB_OFF_PWR_SECOND: read_mux = s.pwr_second;
      `RCB_OFF_PWR_THIRD: read_mux = s.pwr_third;
      `RCB_OFF_MAIN_PROT: read_mux = MAIN_PROT_NV;
      `RCB_OFF_SEC_PROT: read_mux = {i_secure, SEC_PROT_NV[6:0]};
      `RCB_OFF_PAGE: read_mux = s.page;
      `RCB_OFF_ROUTING: read_mux = s.route;
      default: read_mux = `RCB_UNUSED_READ;
    endcase
  endfunction

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    next_st = st;
    next_st.load_first = `RCB_RST_BYTE;
    next_st.load_second = `RCB_RST_BYTE;
    // routing takes the stored setting once after every reset
    if (!st.route_loaded) begin
      next_st.route = ROUTE_NV & `RCB_RT_NV_MASK;
      next_st.route_loaded = 1'b1;
    end
    if (hit && i_rd) begin
      next_st.rdata = read_mux(off, st, pin_sync);
    end
    if (hit && i_wr) begin
      unique case (off)
        `RCB_OFF_A_MODE: next_st.a_mode = i_wdata;
        `RCB_OFF_B_MODE: next_st.b_mode = i_wdata;
        `RCB_OFF_A_OUT: next_st.out_lvl[0] = i_wdata;
        `RCB_OFF_B_OUT: next_st.out_lvl[1] = i_wdata;
        `RCB_OFF_C_OUT: next_st.out_lvl[2] = i_wdata;
        `RCB_OFF_D_OUT: next_st.out_lvl[3] = i_wdata;
        `RCB_OFF_A_DIR: next_st.dir[0] = i_wdata;
        `RCB_OFF_B_DIR: next_st.dir[1] = i_wdata;
        `RCB_OFF_C_DIR: next_st.dir[2] = i_wdata;
        `RCB_OFF_D_DIR: next_st.dir[3] = i_wdata;
        `RCB_OFF_A_DRV: next_st.drive[0] = i_wdata;
        `RCB_OFF_B_DRV: next_st.drive[1] = i_wdata;
        `RCB_OFF_C_DRV: next_st.drive[2] = i_wdata;
        `RCB_OFF_D_DRV: next_st.drive[3] = i_wdata;
        `RCB_OFF_CELL_FIRST: begin
          next_st.load_first = ~st.mask_first;
          next_st.cell_data = i_wdata;
        end
        `RCB_OFF_CELL_SECOND: begin
          next_st.load_second = ~st.mask_second;
          next_st.cell_data = i_wdata;
        end
        `RCB_OFF_MASK_FIRST: next_st.mask_first = i_wdata;
        `RCB_OFF_MASK_SECOND: next_st.mask_second = i_wdata;
        `RCB_OFF_PWR_FIRST: next_st.pwr_first = i_wdata;
        `RCB_OFF_PWR_SECOND: next_st.pwr_second = i_wdata;
        `RCB_OFF_PWR_THIRD: begin
          // sticky bit: software can set it, only reset clears it
          next_st.pwr_third = i_wdata;
          next_st.pwr_third[`RCB_PWR3_STICKY_BIT] =
            i_wdata[`RCB_PWR3_STICKY_BIT] | st.pwr_third[`RCB_PWR3_STICKY_BIT];
        end
        `RCB_OFF_PAGE: next_st.page = i_wdata;
        `RCB_OFF_ROUTING: next_st.route = i_wdata;
        // read-only and unused offsets ignore writes
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  // output level passes out whatever the mode; ports c and d have no mode register and report zero
  assign ctl_reset_route = `RCB_RST_DRIVE;
  assign o_ctl_a = '{level: st.out_lvl[0], dir: st.dir[0], drive: st.drive[0],
                     mode: st.a_mode};
  assign o_ctl_b = '{level: st.out_lvl[1], dir: st.dir[1], drive: st.drive[1],
                     mode: st.b_mode};
  assign o_ctl_c = '{level: st.out_lvl[2], dir: st.dir[2], drive: st.drive[2],
                     mode: ctl_reset_route};
  assign o_ctl_d = '{level: st.out_lvl[3], dir: st.dir[3], drive: st.drive[3],
                     mode: ctl_reset_route};
  assign o_rdata = st.rdata;
  assign o_cell_load_first = st.load_first;
  assign o_cell_load_second = st.load_second;
  assign o_cell_data = st.cell_data;
  assign o_pwr_first = st.pwr_first;
  assign o_pwr_second = st.pwr_second;
  assign o_pwr_third = st.pwr_third;
  assign o_page = st.page;
  assign o_route = '{main_data: st.route[`RCB_RT_MAIN_DATA_BIT],
                     sec_data: st.route[`RCB_RT_SEC_DATA_BIT],
                     main_fetch: st.route[`RCB_RT_MAIN_FETCH_BIT],
                     sec_fetch: st.route[`RCB_RT_SEC_FETCH_BIT],
                     pio_mode: st.route[`RCB_RT_PIO_BIT]};

  // ****************************************
  // checks
  // ****************************************
  AST_PWR3_STICKY: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $past(st.pwr_third[1]) |-> st.pwr_third[1])
    else $error("power third bit 1 cleared without reset");
  AST_ROUTE_INIT: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $rose(st.route_loaded) |-> st.route == (ROUTE_NV & 8'h1E))
    else $error("routing not restored after reset");
  AST_PIO_RESET: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $rose(st.route_loaded) |-> !o_route.pio_mode)
    else $error("peripheral mode set after reset");
  AST_PAGE_WR: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (hit && i_wr && off == 8'hE0) |=> o_page == $past(i_wdata))
    else $error("page write lost");
  AST_PROT_RD: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (hit && i_rd && off == 8'hC0) |=> o_rdata == MAIN_PROT_NV)
    else $error("main protection read wrong");
  AST_MASK_LOAD: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (hit && i_wr && off == 8'h20) |=> o_cell_load_first == ~st.mask_first)
    else $error("masked cell loaded");
  AST_DIR_WR: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (hit && i_wr && off == 8'h06) |=> o_ctl_a.dir == $past(i_wdata))
    else $error("direction write lost");
  AST_UNUSED_RD: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (hit && i_rd && off == 8'h40) |=> o_rdata == 8'h00)
    else $error("unused location read nonzero");
  AST_ROUTE_WR: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (st.route_loaded && hit && i_wr && off == 8'hE2) |=> st.route == $past(i_wdata))
    else $error("routing write lost");
endmodule : rcb_bank
`default_nettype wire

// ==== verification/rcb_far_model.sv ====
`default_nettype none
module rcb_far_model (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // port controls from the bank
  input wire rcb_pkg::rcb_port_ctl_t i_ctl_a,
  input wire rcb_pkg::rcb_port_ctl_t i_ctl_b,
  input wire rcb_pkg::rcb_port_ctl_t i_ctl_c,
  input wire rcb_pkg::rcb_port_ctl_t i_ctl_d,
  // output cell loads
  input wire logic [7:0] i_load_first,
  input wire logic [7:0] i_load_second,
  input wire logic [7:0] i_cell_data,
  // level applied from outside to input pins
  input wire logic [7:0] i_ext,
  // views back into the bank
  output rcb_pkg::rcb_port_in_t o_port_a,
  output rcb_pkg::rcb_port_in_t o_port_b,
  output rcb_pkg::rcb_port_in_t o_port_c,
  output rcb_pkg::rcb_port_in_t o_port_d,
  output logic [7:0] o_drv_on_a,
  output logic [7:0] o_drv_on_b,
  output logic [7:0] o_drv_on_c,
  output logic [7:0] o_drv_on_d,
  output logic [7:0] o_cells_first,
  output logic [7:0] o_cells_second
);
  timeunit 1ns;
  timeprecision 100ps;
  import rcb_pkg::*;
  // ****************************************
  // pins: driven bits follow level, others the outside
  // ****************************************
  function automatic rcb_byte_t pin_of(input rcb_port_ctl_t c, input rcb_byte_t ext);
    return (c.level & c.dir) | (ext & ~c.dir);
  endfunction
  // input cells simply invert the pins, so a stuck view shows up
  assign o_port_a = '{pin_level: pin_of(i_ctl_a, i_ext), in_cells: ~pin_of(i_ctl_a, i_ext),
    cell_out: o_cells_first};
  assign o_port_b = '{pin_level: pin_of(i_ctl_b, i_ext), in_cells: ~pin_of(i_ctl_b, i_ext),
    cell_out: o_cells_second};
  assign o_port_c = '{pin_level: pin_of(i_ctl_c, i_ext), in_cells: ~pin_of(i_ctl_c, i_ext),
    cell_out: o_cells_first};
  assign o_port_d = '{pin_level: pin_of(i_ctl_d, i_ext), in_cells: ~pin_of(i_ctl_d, i_ext),
    cell_out: o_cells_second};
  assign o_drv_on_a = i_ctl_a.dir;
  assign o_drv_on_b = i_ctl_b.dir;
  assign o_drv_on_c = i_ctl_c.dir;
  assign o_drv_on_d = i_ctl_d.dir;
  // ****************************************
  // output cell flip-flops, loaded bit by bit
  // ****************************************
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_cells_first <= 8'h00;
      o_cells_second <= 8'h00;
    end else begin
      o_cells_first <= (o_cells_first & ~i_load_first) | (i_cell_data & i_load_first);
      o_cells_second <= (o_cells_second & ~i_load_second) | (i_cell_data & i_load_second);
    end
  end
endmodule // rcb_far_model
`default_nettype wire

// ==== verification/rcb_bank_tb.sv ====
`default_nettype none
module rcb_bank_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import rcb_pkg::*;
  localparam logic [15:0] BASE = 16'h4500;
  localparam logic [7:0] MAIN_NV = 8'h5A;
  localparam logic [7:0] SEC_NV = 8'h33;
  localparam logic [7:0] ROUTE_NV = 8'h8C;
  localparam logic [7:0] RW_OFF [17] = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08,
    8'h09, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17, 8'hB0, 8'hB4, 8'hE0};
  // per port: pin, input cell, driver-on offsets and level/dir table indices
  localparam logic [7:0] PIN_OFF [4] = '{8'h00, 8'h01, 8'h10, 8'h11};
  localparam logic [7:0] IN_OFF [4] = '{8'h0A, 8'h0B, 8'h18, 8'h19};
  localparam logic [7:0] ON_OFF [4] = '{8'h0C, 8'h0D, 8'h1A, 8'h1B};
  localparam int LVL_IDX [4] = '{2, 3, 8, 9};
  localparam int DIR_IDX [4] = '{4, 5, 10, 11};
  logic i_clk, i_rst_n, i_wr, i_rd, sec;
  logic [15:0] i_addr;
  logic [7:0] i_wdata, o_rdata, ext, lf, ls, cdat, cf, cs, pw1, pw2, pw3, page;
  logic [7:0] on_a, on_b, on_c, on_d, pin;
  rcb_port_in_t pa, pb, pc, pd;
  rcb_port_ctl_t ca, cb, cc, cd;
  rcb_route_t route;
  int mismatches, compares;
  int cyc = 0;
  rcb_bank #(.BASE_ADDR(BASE), .MAIN_PROT_NV(MAIN_NV), .SEC_PROT_NV(SEC_NV),
    .ROUTE_NV(ROUTE_NV)) uut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_wr(i_wr), .i_rd(i_rd),
    .i_addr(i_addr), .i_wdata(i_wdata), .o_rdata(o_rdata), .i_port_a(pa), .i_port_b(pb),
    .i_port_c(pc), .i_port_d(pd), .i_drv_on_a(on_a), .i_drv_on_b(on_b), .i_drv_on_c(on_c),
    .i_drv_on_d(on_d), .i_cells_first(cf), .i_cells_second(cs), .i_secure(sec),
    .o_cell_load_first(lf), .o_cell_load_second(ls), .o_cell_data(cdat), .o_ctl_a(ca),
    .o_ctl_b(cb), .o_ctl_c(cc), .o_ctl_d(cd), .o_pwr_first(pw1), .o_pwr_second(pw2),
    .o_pwr_third(pw3), .o_page(page), .o_route(route));
  rcb_far_model far (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ctl_a(ca), .i_ctl_b(cb),
    .i_ctl_c(cc), .i_ctl_d(cd), .i_load_first(lf), .i_load_second(ls), .i_cell_data(cdat),
    .i_ext(ext), .o_port_a(pa), .o_port_b(pb), .o_port_c(pc), .o_port_d(pd),
    .o_drv_on_a(on_a), .o_drv_on_b(on_b), .o_drv_on_c(on_c), .o_drv_on_d(on_d),
    .o_cells_first(cf), .o_cells_second(cs));
  // ****************************************
  // clock, timeout, verdict
  // ****************************************
  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  task automatic test_done;
    if (mismatches == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // a few hundred bus cycles expected; anything near this is a hang
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      mismatches++;
      test_done();
    end
  end
  // ****************************************
  // bus tasks
  // ****************************************
  function automatic logic [15:0] adr(input logic [7:0] off);
    return {BASE[15:8], off};
  endfunction
  function automatic logic [7:0] pat(input int i);
    return 8'h5A ^ 8'(i);
  endfunction
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  // read data is registered at the edge that takes the request; sample one edge after that
  task automatic rd(input logic [7:0] off, input logic [7:0] exp);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= adr(off);
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(posedge i_clk);
    #1;
    chk(o_rdata, exp);
  endtask
  task automatic do_reset;
    @(posedge i_clk);
    i_rst_n <= 1'b0;
    repeat (5) @(posedge i_clk);
    i_rst_n <= 1'b1;
    repeat (2) @(posedge i_clk);
  endtask
  // ****************************************
  // tests
  // ****************************************
  initial begin
    i_rst_n = 1'b0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 16'h0000;
    i_wdata = 8'h00;
    ext = 8'h3C;
    mismatches = 0;
    compares = 0;
    sec = 1'b1;
    do_reset();
    rd(8'hE2, ROUTE_NV & 8'h1E);
    chk({3'b000, route}, 8'h0C);
    rd(8'hC0, MAIN_NV);
    rd(8'hC2, {1'b1, SEC_NV[6:0]});
    wr(adr(8'hC0), 8'hFF);
    wr(adr(8'hC2), 8'h00);
    rd(8'hC0, MAIN_NV);
    rd(8'hC2, {1'b1, SEC_NV[6:0]});
    @(posedge i_clk);
    sec <= 1'b0;
    rd(8'hC2, {1'b0, SEC_NV[6:0]});
    rd(8'h40, 8'h00);
    for (int i = 0; i < 17; i++) begin
      rd(RW_OFF[i], 8'h00);
      wr(adr(RW_OFF[i]), pat(i));
    end
    for (int i = 0; i < 17; i++) begin
      rd(RW_OFF[i], pat(i));
    end
    chk(ca.mode, pat(0));
    chk(cd.level, pat(9));
    chk(cc.dir, pat(10));
    chk(pw2, pat(15));
    chk(page, pat(16));
    chk(pw1, pat(14));
    chk(cb.drive, pat(7));
    wr(16'h46E0, 8'h77);
    rd(8'hE0, pat(16));
    repeat (6) @(posedge i_clk);
    for (int p = 0; p < 4; p++) begin
      pin = (pat(LVL_IDX[p]) & pat(DIR_IDX[p])) | (ext & ~pat(DIR_IDX[p]));
      wr(adr(PIN_OFF[p]), ~pin);
      // port d has no input cells: that offset is unused, never written
      if (p < 3) begin
        wr(adr(IN_OFF[p]), pin);
      end
      rd(PIN_OFF[p], pin);
      rd(IN_OFF[p], (p < 3) ? ~pin : 8'h00);
      rd(ON_OFF[p], pat(DIR_IDX[p]));
    end
    wr(adr(8'h22), 8'h0F);
    wr(adr(8'h20), 8'hFF);
    wr(adr(8'h23), 8'h00);
    wr(adr(8'h21), 8'h3C);
    rd(8'h22, 8'h0F);
    wr(adr(8'h22), 8'h00);
    rd(8'h20, 8'hF0);
    rd(8'h21, 8'h3C);
    wr(adr(8'h22), 8'hF0);
    rd(8'h20, 8'h00);
    wr(adr(8'hC7), 8'h02);
    rd(8'hC7, 8'h02);
    wr(adr(8'hC7), 8'h00);
    rd(8'hC7, 8'h02);
    chk(pw3, 8'h02);
    wr(adr(8'hE2), 8'h9E);
    rd(8'hE2, 8'h9E);
    chk({3'b000, route}, 8'h1F);
    do_reset();
    rd(8'hC7, 8'h00);
    rd(8'hE2, ROUTE_NV & 8'h1E);
    chk({3'b000, route}, 8'h0C);
    test_done();
  end
endmodule // rcb_bank_tb
`default_nettype wire
